/* File: transceiver_fabric_clocking_test.sv */
// self-checking bench: channel group and fabric joined by the link
module transceiver_fabric_clocking_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = xcv_pkg::NCH;
  localparam int W = xcv_pkg::WORD_W;
  logic                                sys_clk;
  logic                                rst;
  logic [N-1:0]                        rx_line;
  logic                                cfg_bonded;
  logic                                cfg_direct;
  logic                                cfg_byte_deser;
  logic                                cfg_gen2;
  logic                                cfg_rate_match;
  logic [N-1:0][xcv_pkg::SYN_W-1:0]    synth_sel;
  logic [N-1:0][xcv_pkg::CFG_W-1:0]    tx_cfg;
  logic [N-1:0][W-1:0]                 tx_word_out;
  logic [N-1:0]                        tx_word_vld;
  logic                                rx_detect_done;
  logic [N-1:0][W-1:0]                 tx_word;
  logic [N-1:0]                        tx_req;
  logic [N-1:0]                        tx_taken;
  logic [N-1:0][W-1:0]                 cap_data;
  logic [N-1:0]                        cap_vld;
  logic [15:0]                         rnd;
  logic [W-1:0]                        txq[N][$];
  int                                  cnt[N];
  int                                  num_errors = 0;
  int                                  cmp_count = 0;
  bit                                  bond_eq = 0;
  xcv_link_if link();
  xcv_dev u_xcv_dev (.sys_clk(sys_clk), .rst(rst), .link(link),
    .rx_line(rx_line), .cfg_bonded(cfg_bonded), .cfg_direct(cfg_direct),
    .cfg_byte_deser(cfg_byte_deser), .cfg_gen2(cfg_gen2),
    .cfg_rate_match(cfg_rate_match), .synth_sel(synth_sel),
    .tx_cfg(tx_cfg), .tx_word_out(tx_word_out),
    .tx_word_vld(tx_word_vld), .rx_detect_done(rx_detect_done));
  xcv_fab u_xcv_fab (.sys_clk(sys_clk), .rst(rst), .link(link),
    .tx_word(tx_word), .tx_req(tx_req), .tx_taken(tx_taken),
    .cap_data(cap_data), .cap_vld(cap_vld));
  xcv_link_properties u_xcv_link_properties (.sys_clk(sys_clk),
    .rst(rst), .rx_ck(link.rx_ck), .rx_data(link.rx_data),
    .tx_ck(link.tx_ck), .tx_src(link.tx_src), .tx_data(link.tx_data),
    .tx_vld(link.tx_vld), .fixed_ck(link.fixed_ck),
    .reconf_ck(link.reconf_ck), .cal_ck(link.cal_ck));
  initial
  begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // lowest channel with the same synthesizer and setup leads the group
  function automatic int lead(input int i);
    lead = i;
    for (int j = i - 1; j >= 0; j--)
      if (synth_sel[j] === synth_sel[i] && tx_cfg[j] === tx_cfg[i])
        lead = j;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [W-1:0] e,
                     input logic [W-1:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi,
                         input int g);
    cmp_count++;
    if (g < lo || g > hi)
    begin
      num_errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic chk_src;
    int e;
    for (int i = 0; i < N; i++)
    begin
      e = (cfg_bonded && !cfg_direct) ? 0 : lead(i);
      chk("tx_src", W'(e), W'(link.tx_src[i]));
    end
  endtask
  // traffic is paused around a change so no word meets a clock switch
  task automatic set_cfg(input logic b, d, y, g, r);
    tx_req = '0;
    tick(10);
    {cfg_bonded, cfg_direct, cfg_byte_deser, cfg_gen2, cfg_rate_match} =
      {b, d, y, g, r};
    tick(12);
    cnt = '{default: 0};
  endtask
  task automatic print_verdict;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(negedge sys_clk)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (cap_vld[i] === 1'b1)
        cnt[i]++;
      if (tx_taken[i] === 1'b1)
      begin
        txq[i].push_back(tx_word[i]);
        rnd = lfsr(rnd);
        tx_word[i] = rnd;
      end
      if (tx_word_vld[i] === 1'b1)
        chk("tx_word_out", txq[i].size() ? txq[i].pop_front() : 16'hdead,
            tx_word_out[i]);
    end
    if (bond_eq)
      chk("cap_vld", W'({N{cap_vld[0]}}), W'(cap_vld));
  end
  initial
  begin
    rnd = 16'h04ca;
    {tx_word, tx_req, rx_line, synth_sel, tx_cfg} = '0;
    {cfg_bonded, cfg_direct, cfg_byte_deser, cfg_gen2, cfg_rate_match} = '0;
    rst = 1;
    tick(4);
    rst = 0;
    tick(1);
    chk("cap_vld", '0, W'(cap_vld));
    chk("rx_detect_done", '0, W'(rx_detect_done));
    tick(20);
    chk("rx_detect_done", '0, W'(rx_detect_done));
    tick(20);
    chk("rx_detect_done", 16'h0001, W'(rx_detect_done));
    for (int i = 0; i < N; i++)
    begin
      synth_sel[i] = 1'(i == 2 || i == 3);
      tx_cfg[i] = (i < 4) ? 8'h05 : 8'(16 + i);
    end
    set_cfg(0, 0, 0, 0, 0);
    chk_src;
    tx_req = '1;
    tick(200);
    repeat (5)
    begin
      for (int i = 0; i < N; i++)
      begin
        rnd = lfsr(rnd);
        synth_sel[i] = rnd[0];
        tx_cfg[i] = {6'h00, rnd[2:1]};
      end
      set_cfg(0, 0, 0, 0, 0);
      chk_src;
    end
    for (int m = 0; m < 4; m++)
    begin
      set_cfg(m < 3, 0, m == 1, m == 2, 1);
      chk_src;
      tx_req = '1;
      bond_eq = (m < 3);
      tick(40);
      bond_eq = 0;
      chk_rng("rx_ticks", m % 3 ? 19 : 39, m % 3 ? 21 : 41,
              cnt[0]);
    end
    for (int m = 0; m < 2; m++)
    begin
      set_cfg(1, m == 0, 0, 0, 0);
      chk_src;
      for (int k = 0; k < N; k++)
      begin
        cnt = '{default: 0};
        repeat (100)
        begin
          rx_line[k] = ~rx_line[k];
          // each level must stand two cycles to get past the pin filter
          tick(2);
        end
        tick(12);
        for (int i = 0; i < N; i++)
          chk_rng("rx_ticks", i == k ? 9 : 0, i == k ? 10 : 0,
                  cnt[i]);
        if (m == 0)
        begin
          chk("raw_pad", '0, W'(cap_data[k][W-1:xcv_pkg::SYM_W]));
          // alternating line from low, even count: newest bit low
          chk("raw_word", 16'h02aa, cap_data[k]);
        end
      end
    end
    tick(20);
    for (int i = 0; i < N; i++)
      chk_rng("tx_words_left", 0, 0, txq[i].size());
    print_verdict;
  end
  initial
  begin
    #80000;
    num_errors++;
    print_verdict;
  end
endmodule

/* File: xcv_dev.sv */
// transceiver channel group: recovered clocks, bonding and forwarding
// -----------------------------------------------------------------
// rules
// -----------------------------------------------------------------
// Contract
// RULE1: each channel recovers and divides its own clock
// RULE2: recovered parallel clock feeds aligner, rate-match write
// RULE3: clock unit drives rate-match read, decode, pairing
// RULE4: interface clock writes rx fifo, forwarded shared
// RULE5: gen1 250/125, gen2 forces byte pairing
// RULE6: direct mode forwards recovered clock per channel
// RULE7: direct mode receivers never bond
// RULE8: fabric captures with that channel's own clock
// RULE9: tx clock forwarded local or shared bonded
// RULE10: rx clock recovered, or tx/shared with rate-match
// RULE11: fabric supplies fixed 125 MHz clock
// RULE12: direct offers only tx/rx clocks, rx separate
// RULE13: reconfiguration clock free-running, fabric-derived
// RULE14: tx fifo absorbs write/read phase offset
// RULE15: tx fifo write clock same frequency as read
// RULE16: identical channels share synth and tx setup
// RULE17: lowest identical channel clocks its group
// RULE18: bonded rx fifos share central pointers
module xcv_dev #(
  parameter int NCH = xcv_pkg::NCH
)
(
  input  wire logic                                  sys_clk,
  input  wire logic                                  rst,
  xcv_link_if.dev                                    link,
  input  wire logic [NCH-1:0]                        rx_line,
  input  wire logic                                  cfg_bonded,
  input  wire logic                                  cfg_direct,
  input  wire logic                                  cfg_byte_deser,
  input  wire logic                                  cfg_gen2,
  input  wire logic                                  cfg_rate_match,
  input  wire logic [NCH-1:0][xcv_pkg::SYN_W-1:0]    synth_sel,
  input  wire logic [NCH-1:0][xcv_pkg::CFG_W-1:0]    tx_cfg,
  output logic      [NCH-1:0][xcv_pkg::WORD_W-1:0]   tx_word_out,
  output logic      [NCH-1:0]                        tx_word_vld,
  output logic                                       rx_detect_done
);
  localparam int AW = xcv_pkg::FIFO_AW;
  localparam int DEPTH = 1 << AW;
  localparam int IW = xcv_pkg::IDX_W;
  localparam int KW = xcv_pkg::SYN_W + xcv_pkg::CFG_W;
  localparam logic [AW-1:0] PC_LAT = AW'(xcv_pkg::PC_LAT);
  localparam logic [xcv_pkg::RDET_W-1:0] RDET_END =
    xcv_pkg::RDET_W'(xcv_pkg::RDET_TICKS);

  // lowest channel whose synthesizer and tx setup match channel idx
  function automatic logic [IW-1:0] first_ident(
    input logic [NCH-1:0][KW-1:0] keys,
    input int                     idx
  );
    logic found;
    found = 1'b0;
    first_ident = IW'(idx);
    for (int j = 0; j < NCH; j++)
      if (!found && keys[j] == keys[idx])
      begin
        first_ident = IW'(j);
        found = 1'b1;
      end
  endfunction

  // -----------------------------------------------------------------
  // mode latch: new settings take effect on a reconfiguration tick
  // -----------------------------------------------------------------
  logic bond_reg;
  logic direct_reg;
  logic bdes_reg;
  logic rm_reg;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      bond_reg   <= 1'b0;
      direct_reg <= 1'b0;
      bdes_reg   <= 1'b0;
      rm_reg     <= 1'b0;
    end
    else if (link.reconf_ck)
    begin
      bond_reg   <= cfg_bonded & ~cfg_direct;                 // RULE7
      direct_reg <= cfg_direct;
      bdes_reg   <= cfg_byte_deser | cfg_gen2;                // RULE5
      rm_reg     <= cfg_rate_match & ~cfg_direct;
    end
  end

  // -----------------------------------------------------------------
  // central clock unit: low-speed clock and shared interface clock
  // -----------------------------------------------------------------
  logic lsp_tick;
  logic half_reg;
  logic core_reg;
  wire  core_next = lsp_tick & (~bdes_reg | half_reg);        // RULE4

  xcv_div #(.RATIO(xcv_pkg::LSP_DIV), .PHASE(0)) u_cu (
    .sys_clk (sys_clk),
    .rst     (rst),
    .en      (1'b1),
    .tick    (lsp_tick)
  );

  // pointers are shared so every bonded channel sees equal latency
  logic [AW-1:0] pc_wp_reg;
  wire  [AW-1:0] pc_rp = pc_wp_reg - PC_LAT;                  // RULE18

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      half_reg  <= 1'b0;
      core_reg  <= 1'b0;
      pc_wp_reg <= '0;
    end
    else
    begin
      if (lsp_tick)
        half_reg <= bdes_reg & ~half_reg;
      core_reg <= core_next;
      if (core_reg)
        pc_wp_reg <= pc_wp_reg + AW'(1);
    end
  end

  // -----------------------------------------------------------------
  // receiver detect / equaliser timing on the fabric's fixed clock
  // -----------------------------------------------------------------
  logic [xcv_pkg::RDET_W-1:0] rdet_reg;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rdet_reg       <= '0;
      rx_detect_done <= 1'b0;
    end
    else
    begin
      if (link.fixed_ck && rdet_reg != RDET_END)              // RULE11
        rdet_reg <= rdet_reg + xcv_pkg::RDET_W'(1);
      rx_detect_done <= (rdet_reg == RDET_END);
    end
  end

  // -----------------------------------------------------------------
  // per-channel datapath
  // -----------------------------------------------------------------
  wire [NCH-1:0]         tx_loc;
  wire [NCH-1:0][KW-1:0] tx_key;

  genvar i;
  generate
    for (i = 0; i < NCH; i++)
    begin : g_ch
      // pin synchroniser; s1 is read only by s2
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic lvl_reg;
      logic ser_reg;
      logic [xcv_pkg::SYM_W-1:0] des_reg;
      logic [xcv_pkg::SYM_W-1:0] aln_reg;
      logic par_tick;
      wire  edge_seen = (s2_reg == s3_reg) && (s3_reg != lvl_reg);

      // serial clock recovered from this channel's own transitions
      always_ff @(posedge sys_clk)
      begin
        if (rst)
        begin
          s1_reg  <= 1'b0;
          s2_reg  <= 1'b0;
          s3_reg  <= 1'b0;
          lvl_reg <= 1'b0;
          ser_reg <= 1'b0;
          des_reg <= '0;
          aln_reg <= '0;
        end
        else
        begin
          s1_reg  <= rx_line[i];
          s2_reg  <= s1_reg;
          s3_reg  <= s2_reg;
          ser_reg <= edge_seen;                               // RULE1
          if (edge_seen)
          begin
            lvl_reg <= s3_reg;
            des_reg <= {des_reg[xcv_pkg::SYM_W-2:0], s3_reg};
          end
          if (par_tick)
            aln_reg <= des_reg;                               // RULE2
        end
      end

      xcv_div #(.RATIO(xcv_pkg::SER_DIV), .PHASE(0)) u_par (
        .sys_clk (sys_clk),
        .rst     (rst),
        .en      (ser_reg),
        .tick    (par_tick)                                   // RULE1
      );

      // rate matcher: drops on overflow, repeats on underflow
      logic [xcv_pkg::SYM_W-1:0] rm_mem [DEPTH];
      logic [AW:0]               rm_wp_reg;
      logic [AW:0]               rm_rp_reg;
      logic [xcv_pkg::SYM_W-1:0] rm_out_reg;
      wire rm_full  = (rm_wp_reg ^ rm_rp_reg) == {1'b1, {AW{1'b0}}};
      wire rm_empty = (rm_wp_reg == rm_rp_reg);
      wire [xcv_pkg::SYM_W-1:0] sym = rm_reg ? rm_out_reg : aln_reg;
      wire [xcv_pkg::BYTE_W-1:0] dec = xcv_pkg::sym_to_byte(sym);

      always_ff @(posedge sys_clk)
      begin
        if (par_tick && !rm_full)
          rm_mem[rm_wp_reg[AW-1:0]] <= aln_reg;               // RULE2
      end

      always_ff @(posedge sys_clk)
      begin
        if (rst)
        begin
          rm_wp_reg  <= '0;
          rm_rp_reg  <= '0;
          rm_out_reg <= '0;
        end
        else
        begin
          if (par_tick && !rm_full)
            rm_wp_reg <= rm_wp_reg + (AW+1)'(1);
          if (lsp_tick && !rm_empty)                          // RULE3
          begin
            rm_out_reg <= rm_mem[rm_rp_reg[AW-1:0]];
            rm_rp_reg  <= rm_rp_reg + (AW+1)'(1);
          end
        end
      end

      // byte pairing and receive phase compensation fifo
      logic [xcv_pkg::BYTE_W-1:0] lo_reg;
      logic [xcv_pkg::WORD_W-1:0] word_reg;
      logic [xcv_pkg::WORD_W-1:0] pc_mem [DEPTH];

      always_ff @(posedge sys_clk)
      begin
        if (rst)
        begin
          lo_reg   <= '0;
          word_reg <= '0;
        end
        else if (lsp_tick)                                    // RULE3
        begin
          if (bdes_reg && !half_reg)
            lo_reg <= dec;
          else if (bdes_reg)
            word_reg <= {dec, lo_reg};
          else
            word_reg <= {{xcv_pkg::BYTE_W{1'b0}}, dec};
        end
      end

      always_ff @(posedge sys_clk)
      begin
        if (core_reg)
          pc_mem[pc_wp_reg] <= word_reg;                      // RULE4
      end

      // forwarded receive clock and data
      wire tx_rd_ck = bond_reg ? core_reg : tx_loc[i];
      wire rx_use_rec = direct_reg | ~rm_reg;
      wire rx_ck_next = rx_use_rec ? par_tick : tx_rd_ck;     // RULE10
      wire [xcv_pkg::WORD_W-1:0] rx_d_next = direct_reg ?
        xcv_pkg::WORD_W'(aln_reg) : pc_mem[pc_rp];            // RULE6

      always_ff @(posedge sys_clk)
      begin
        if (rst)
        begin
          link.rx_ck[i]   <= 1'b0;
          link.rx_data[i] <= '0;
        end
        else
        begin
          link.rx_ck[i]   <= rx_ck_next;                      // RULE12
          link.rx_data[i] <= rx_d_next;
        end
      end

      // transmit: local divider, group write clock, phase fifo
      xcv_div #(.RATIO(xcv_pkg::LSP_DIV), .PHASE(i)) u_tx (
        .sys_clk (sys_clk),
        .rst     (rst),
        .en      (1'b1),
        .tick    (tx_loc[i])
      );

      assign tx_key[i] = {synth_sel[i], tx_cfg[i]};           // RULE16
      wire [IW-1:0] src = first_ident(tx_key, i);             // RULE17
      wire wr_ck = bond_reg ? core_reg : tx_loc[src];         // RULE15

      logic [xcv_pkg::WORD_W-1:0] tx_mem [DEPTH];
      logic [AW:0]                tx_wp_reg;
      logic [AW:0]                tx_rp_reg;
      wire tx_full  = (tx_wp_reg ^ tx_rp_reg) == {1'b1, {AW{1'b0}}};
      wire tx_empty = (tx_wp_reg == tx_rp_reg);
      wire tx_wr = wr_ck & link.tx_vld[i] & ~tx_full;
      wire tx_rd = tx_rd_ck & ~tx_empty;

      always_ff @(posedge sys_clk)
      begin
        if (tx_wr)
          tx_mem[tx_wp_reg[AW-1:0]] <= link.tx_data[i];       // RULE14
      end

      always_ff @(posedge sys_clk)
      begin
        if (rst)
        begin
          tx_wp_reg      <= '0;
          tx_rp_reg      <= '0;
          tx_word_out[i] <= '0;
          tx_word_vld[i] <= 1'b0;
          link.tx_ck[i]  <= 1'b0;
          link.tx_src[i] <= '0;
        end
        else
        begin
          if (tx_wr)
            tx_wp_reg <= tx_wp_reg + (AW+1)'(1);
          if (tx_rd)
          begin
            tx_word_out[i] <= tx_mem[tx_rp_reg[AW-1:0]];      // RULE14
            tx_rp_reg      <= tx_rp_reg + (AW+1)'(1);
          end
          tx_word_vld[i] <= tx_rd;
          link.tx_ck[i]  <= tx_rd_ck;                         // RULE9
          link.tx_src[i] <= bond_reg ? '0 : src;
        end
      end
    end
  endgenerate
endmodule

/* File: xcv_div.sv */
// tick divider: one output pulse every RATIO enabled cycles
module xcv_div #(
  parameter int RATIO = 2,
  parameter int PHASE = 0
)
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic en,
  output logic      tick
);
  localparam int CW = (RATIO > 1) ? $clog2(RATIO) : 1;
  localparam logic [CW-1:0] LAST  = CW'(RATIO - 1);
  localparam logic [CW-1:0] START = CW'(PHASE % RATIO);

  logic [CW-1:0] cnt_reg;
  wire           wrap = (cnt_reg == LAST);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cnt_reg <= START;
      tick    <= 1'b0;
    end
    else
    begin
      tick <= en & wrap;
      if (en)
        cnt_reg <= wrap ? '0 : cnt_reg + CW'(1);
    end
  end
endmodule

/* File: xcv_fab.sv */
// fabric user logic end: clocks toward the channels, capture, transmit
module xcv_fab #(
  parameter int NCH = xcv_pkg::NCH
)
(
  input  wire logic                                sys_clk,
  input  wire logic                                rst,
  xcv_link_if.fab                                  link,
  input  wire logic [NCH-1:0][xcv_pkg::WORD_W-1:0] tx_word,
  input  wire logic [NCH-1:0]                      tx_req,
  output logic      [NCH-1:0]                      tx_taken,
  output logic      [NCH-1:0][xcv_pkg::WORD_W-1:0] cap_data,
  output logic      [NCH-1:0]                      cap_vld
);
  // -----------------------------------------------------------------
  // auxiliary clocks from the fabric's own free-running clock
  // -----------------------------------------------------------------
  // nothing here looks at a link clock, so these keep running
  // through any reconfiguration; only the shared rst stops them
  xcv_div #(.RATIO(xcv_pkg::FIXED_DIV), .PHASE(0)) u_fixed (
    .sys_clk (sys_clk),
    .rst     (rst),
    .en      (1'b1),
    .tick    (link.fixed_ck)                                  // RULE11
  );

  xcv_div #(.RATIO(xcv_pkg::RECONF_DIV), .PHASE(0)) u_reconf (
    .sys_clk (sys_clk),
    .rst     (rst),
    .en      (1'b1),
    .tick    (link.reconf_ck)                                 // RULE13
  );

  xcv_div #(.RATIO(xcv_pkg::CAL_DIV), .PHASE(0)) u_cal (
    .sys_clk (sys_clk),
    .rst     (rst),
    .en      (1'b1),
    .tick    (link.cal_ck)
  );

  // -----------------------------------------------------------------
  // per-channel capture and transmit presentation
  // -----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NCH; i++)
    begin : g_ch
      // transmit logic runs on the clock of its group leader
      wire grp_ck = link.tx_ck[link.tx_src[i]];               // RULE17
      wire send = grp_ck & tx_req[i];                         // RULE9

      always_ff @(posedge sys_clk)
      begin
        if (rst)
        begin
          link.tx_data[i] <= '0;
          link.tx_vld[i]  <= 1'b0;
          tx_taken[i]     <= 1'b0;
          cap_data[i]     <= '0;
          cap_vld[i]      <= 1'b0;
        end
        else
        begin
          link.tx_vld[i] <= send;                             // RULE15
          tx_taken[i]    <= send;
          if (send)
            link.tx_data[i] <= tx_word[i];
          cap_vld[i] <= link.rx_ck[i];                        // RULE8
          if (link.rx_ck[i])
            cap_data[i] <= link.rx_data[i];                   // RULE12
        end
      end
    end
  endgenerate
endmodule

/* File: xcv_link_if.sv */
// link between the transceiver channel group and fabric user logic
interface xcv_link_if #(parameter int NCH = xcv_pkg::NCH);
  logic [NCH-1:0]                      rx_ck;
  logic [NCH-1:0][xcv_pkg::WORD_W-1:0] rx_data;
  logic [NCH-1:0]                      tx_ck;
  logic [NCH-1:0][xcv_pkg::IDX_W-1:0]  tx_src;
  logic [NCH-1:0][xcv_pkg::WORD_W-1:0] tx_data;
  logic [NCH-1:0]                      tx_vld;
  logic                                fixed_ck;
  logic                                reconf_ck;
  logic                                cal_ck;

  modport dev (
    output rx_ck, rx_data, tx_ck, tx_src,
    input  tx_data, tx_vld, fixed_ck, reconf_ck, cal_ck
  );
  modport fab (
    input  rx_ck, rx_data, tx_ck, tx_src,
    output tx_data, tx_vld, fixed_ck, reconf_ck, cal_ck
  );
endinterface

/* File: xcv_link_properties.sv */
// link checker: auxiliary clock rates and transmit group clocking
module xcv_link_properties #(
  parameter int NCH = xcv_pkg::NCH
)
(
  input wire logic                                sys_clk,
  input wire logic                                rst,
  input wire logic [NCH-1:0]                      rx_ck,
  input wire logic [NCH-1:0][xcv_pkg::WORD_W-1:0] rx_data,
  input wire logic [NCH-1:0]                      tx_ck,
  input wire logic [NCH-1:0][xcv_pkg::IDX_W-1:0]  tx_src,
  input wire logic [NCH-1:0][xcv_pkg::WORD_W-1:0] tx_data,
  input wire logic [NCH-1:0]                      tx_vld,
  input wire logic                                fixed_ck,
  input wire logic                                reconf_ck,
  input wire logic                                cal_ck
);
  default clocking dcb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // leader tick delayed one cycle to line up with the fabric strobe
  logic [NCH-1:0] lead_d;
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < NCH; i++)
      lead_d[i] <= tx_ck[tx_src[i]];
  end
  property p_fixed_gap;
    fixed_ck |=> !fixed_ck;
  endproperty
  a_fixed_gap: assert property (p_fixed_gap)
    else $error("fixed clock high two cycles running");
  property p_fixed_next;
    fixed_ck ##1 !fixed_ck |=> fixed_ck;
  endproperty
  a_fixed_next: assert property (p_fixed_next)
    else $error("fixed clock tick missing");
  property p_reconf_gap;
    reconf_ck |=> !reconf_ck [*3];
  endproperty
  a_reconf_gap: assert property (p_reconf_gap)
    else $error("reconfiguration tick too early");
  property p_reconf_next;
    reconf_ck ##1 !reconf_ck [*3] |=> reconf_ck;
  endproperty
  a_reconf_next: assert property (p_reconf_next)
    else $error("reconfiguration clock stopped");
  property p_cal_rate;
    cal_ck |=> !cal_ck [*7] ##1 cal_ck;
  endproperty
  a_cal_rate: assert property (p_cal_rate)
    else $error("calibration clock off rate");
  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    property p_tx_lead;
      tx_vld[i] |-> lead_d[i];
    endproperty
    a_tx_lead: assert property (p_tx_lead)
      else $error("tx strobe without group clock tick");
    property p_tx_hold;
      !tx_vld[i] |-> $stable(tx_data[i]);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
      else $error("tx data moved without strobe");
    property p_src_low;
      tx_src[i] <= i;
    endproperty
    a_src_low: assert property (p_src_low)
      else $error("group leader above member");
    property p_src_self;
      tx_src[tx_src[i]] == tx_src[i];
    endproperty
    a_src_self: assert property (p_src_self)
      else $error("group leader not its own leader");
  end
endmodule

/* File: xcv_pkg.sv */
// shared constants and helpers for the transceiver clocking model
package xcv_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int NCH      = 8;
  localparam int IDX_W    = $clog2(NCH);
  localparam int SYM_W    = 10;
  localparam int BYTE_W   = 8;
  localparam int WORD_W   = 16;
  localparam int SYN_W    = 1;
  localparam int CFG_W    = 8;
  localparam int FIFO_AW  = 2;
  localparam int PC_LAT   = 2;

  // ---------------------------------------------------------------
  // rates
  // ---------------------------------------------------------------
  localparam int SYS_MHZ      = 250;
  localparam int GEN1_PAR_MHZ = 250;
  localparam int GEN2_PAR_MHZ = 500;
  localparam int FIXED_MHZ    = 125;
  localparam int LSP_DIV      = SYS_MHZ / GEN1_PAR_MHZ;
  localparam int FIXED_DIV    = SYS_MHZ / FIXED_MHZ;
  localparam int SER_DIV      = SYM_W;
  localparam int RECONF_DIV   = 4;
  localparam int CAL_DIV      = 8;
  localparam int RDET_TICKS   = 16;
  localparam int RDET_W       = $clog2(RDET_TICKS + 1);

  // stand-in for the 8b/10b table: keeps the data bits of a symbol
  function automatic logic [BYTE_W-1:0] sym_to_byte(
    input logic [SYM_W-1:0] sym
  );
    sym_to_byte = sym[BYTE_W-1:0];
  endfunction

endpackage
